/* arp_pkg.sv */
// Constants, codes and state encodings for the address resolution agent.
// Assumes a single clock domain; consumed by smbus_arp_slave_agent, arp_host_model and tb_top.
package arp_pkg;

	// Fixed bus address reserved for address resolution traffic
	localparam logic [6:0]  ARP_ADDR       = 7'h61;

	// Command codes
	localparam logic [7:0]  CMD_PREPARE    = 8'h01;
	localparam logic [7:0]  CMD_RESET      = 8'h02;
	localparam logic [7:0]  CMD_GET        = 8'h03;
	localparam logic [7:0]  CMD_ASSIGN     = 8'h04;

	// Byte count announced in identifier transfers
	localparam logic [7:0]  BYTE_COUNT     = 8'h11;

	// Positions inside the data phase (index 0 is the first byte after the command)
	localparam logic [4:0]  IDX_UDID_FIRST = 5'h01;
	localparam logic [4:0]  IDX_UDID_LAST  = 5'h10;
	localparam logic [4:0]  IDX_NEW_ADDR   = 5'h11;
	localparam logic [4:0]  IDX_PEC        = 5'h12;
	localparam logic [4:0]  IDX_UDID_BASE  = 5'h10;
	localparam logic [4:0]  IDX_SHORT_END  = 5'h01;
	localparam logic [4:0]  IDX_ASSIGN_END = 5'h13;

	// Identifier fields
	localparam logic [7:0]  UDID_CAPS      = 8'h80;
	localparam logic [15:0] UDID_IFACE     = 16'h0005;
	localparam logic [7:0]  UDID_VERSION   = 8'h21;       // Arbitrary value
	localparam logic [15:0] UDID_VENDOR    = 16'h1234;    // Arbitrary value
	localparam logic [15:0] UDID_DEVICE    = 16'h4000;    // Arbitrary value
	localparam logic [31:0] UDID_VSPEC     = 32'h0badf00d; // Arbitrary value
	localparam logic [15:0] SUBSYS_DEFAULT = 16'h0000;    // Arbitrary value

	// Upper four bits of each function's default bus address
	localparam logic [3:0]  TSENS_BASE     = 4'h3;
	localparam logic [3:0]  MEM_BASE       = 4'ha;

	// CRC-8 generator x8 + x2 + x + 1
	localparam logic [7:0]  CRC_POLY       = 8'h07;

	// Bit counter value of the acknowledge clock
	localparam logic [3:0]  BIT_ACK        = 4'h8;
	localparam logic [3:0]  BIT_LAST       = 4'h7;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'b000001,
		ST_ADDR  = 6'b000010,
		ST_CMD   = 6'b000100,
		ST_WDATA = 6'b001000,
		ST_RDATA = 6'b010000,
		ST_SKIP  = 6'b100000
	} state_type;

	typedef enum logic [2:0] {
		ACT_NONE    = 3'h0,
		ACT_PREP    = 3'h1,
		ACT_RST_ALL = 3'h2,
		ACT_RST_ONE = 3'h3,
		ACT_GET     = 3'h4,
		ACT_ASSIGN  = 3'h5
	} act_type;

endpackage

/* smbus_arp_slave_agent.sv */
// Address resolution agent for a two-function bus slave (sensor and memory).
// Assumes open-drain SDA resolved outside; SCL/SDA/select pins are asynchronous.
`timescale 1ns/1ps

module smbus_arp_slave_agent (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire logic        addr_select_in0,
	input  wire logic        addr_select_in1,
	input  wire logic        addr_select_in2,
	input  wire logic [15:0] subsys_vendor_in,
	input  wire logic [15:0] subsys_device_in,
	input  wire logic        subsys_load,
	output logic [6:0]       tsens_addr,
	output logic [6:0]       mem_addr,
	output logic             tsens_resolved,
	output logic             mem_resolved
);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ arp_pkg::CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// Byte k of function fn's identifier; k = 15 is the capabilities byte
	function automatic logic [7:0] udid_byte(input logic fn, input logic [3:0] k,
			input logic [15:0] sv, input logic [15:0] sd);
		logic [127:0] u;
		u = {arp_pkg::UDID_CAPS, arp_pkg::UDID_VERSION, arp_pkg::UDID_VENDOR,
			arp_pkg::UDID_DEVICE[15:1], fn,
			arp_pkg::UDID_IFACE, sv, sd, arp_pkg::UDID_VSPEC};
		return u[{k, 3'b000} +: 8];
	endfunction

	// Synchronisers and edge detection
	logic [1:0]      scl_sync;
	logic [1:0]      sda_sync;
	logic [2:0]      sa_meta;
	logic [2:0]      sa_sync;
	logic            scl_prev;
	logic            sda_prev;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
			sa_meta  <= 3'h0;
			sa_sync  <= 3'h0;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_prev <= scl_sync[1];
			sda_prev <= sda_sync[1];
			sa_meta  <= {addr_select_in2, addr_select_in1, addr_select_in0};
			sa_sync  <= sa_meta;
		end
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl_s     = scl_sync[1];
	assign sda_s     = sda_sync[1];
	assign scl_rise  = scl_s & ~scl_prev;
	assign scl_fall  = ~scl_s & scl_prev;
	assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
	assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

	// Rewritable subsystem identifier storage
	logic [15:0] subsys_vendor;
	logic [15:0] subsys_device;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			subsys_vendor <= arp_pkg::SUBSYS_DEFAULT;
			subsys_device <= arp_pkg::SUBSYS_DEFAULT;
		end else if (subsys_load) begin
			subsys_vendor <= subsys_vendor_in;
			subsys_device <= subsys_device_in;
		end
	end

	// Per-function resolution state
	logic [1:0] address_resolved_flag;
	logic [1:0] assigned;
	logic [6:0] asg_addr [2];
	logic [6:0] cur_addr [2];
	logic [6:0] dflt_addr [2];

	assign dflt_addr[0] = {arp_pkg::TSENS_BASE, sa_sync};
	assign dflt_addr[1] = {arp_pkg::MEM_BASE, sa_sync};

	// Transaction engine state
	arp_pkg::state_type state;
	arp_pkg::act_type   act;
	arp_pkg::act_type   dec_act;
	logic [3:0]         bit_cnt;
	logic [7:0]         shreg;
	logic [4:0]         byte_idx;
	logic [7:0]         crc;
	logic [7:0]         tx_byte;
	logic [7:0]         next_tx;
	logic [6:0]         new_addr;
	logic [1:0]         match;
	logic               sel_fn;
	logic               dec_fn;
	logic               dec_hit;
	logic               cmd_valid;
	logic               pec_ok;
	logic               ack_pend;
	logic [7:0]         rx_byte;
	logic [7:0]         next_crc;
	logic               byte_end;
	logic               commit;
	logic [4:0]         next_idx;

	assign rx_byte  = {shreg[6:0], sda_s};
	assign byte_end = scl_rise && bit_cnt == arp_pkg::BIT_LAST;
	assign next_crc = crc8(crc, (state == arp_pkg::ST_RDATA) ? tx_byte : rx_byte);
	assign next_idx = byte_idx + 5'h01;

	// Command decode, general and directed
	always_comb begin
		dec_act = arp_pkg::ACT_NONE;
		dec_fn  = 1'b0;
		dec_hit = 1'b1;
		unique case (rx_byte)
			arp_pkg::CMD_PREPARE: dec_act = arp_pkg::ACT_PREP;
			arp_pkg::CMD_RESET:   dec_act = arp_pkg::ACT_RST_ALL;
			arp_pkg::CMD_ASSIGN:  dec_act = arp_pkg::ACT_ASSIGN;
			arp_pkg::CMD_GET: begin
				// Both functions share one pin pair; the sensor wins internally
				dec_act = arp_pkg::ACT_GET;
				if (!address_resolved_flag[0]) begin
					dec_fn = 1'b0;
				end else if (!address_resolved_flag[1]) begin
					dec_fn = 1'b1;
				end else begin
					dec_hit = 1'b0;
				end
			end
			default: begin
				if (rx_byte[7:1] == cur_addr[0] || rx_byte[7:1] == cur_addr[1]) begin
					dec_fn  = (rx_byte[7:1] == cur_addr[1]);
					dec_act = rx_byte[0] ? arp_pkg::ACT_GET : arp_pkg::ACT_RST_ONE;
				end else begin
					dec_hit = 1'b0;
				end
			end
		endcase
	end

	// Next byte to send during an identifier read
	always_comb begin
		next_tx = 8'hff;
		if (next_idx >= arp_pkg::IDX_UDID_FIRST && next_idx <= arp_pkg::IDX_UDID_LAST) begin
			next_tx = udid_byte(sel_fn, 4'(arp_pkg::IDX_UDID_BASE - next_idx),
				subsys_vendor, subsys_device);
		end else if (next_idx == arp_pkg::IDX_NEW_ADDR) begin
			next_tx = {cur_addr[sel_fn], 1'b1};
		end else if (next_idx == arp_pkg::IDX_PEC) begin
			next_tx = next_crc;
		end
	end

	// A write transaction takes effect only at its stop, after a good code byte
	assign commit = stop_det && cmd_valid && pec_ok && state == arp_pkg::ST_WDATA &&
		(act == arp_pkg::ACT_ASSIGN ? byte_idx == arp_pkg::IDX_ASSIGN_END
			: (act != arp_pkg::ACT_GET && byte_idx == arp_pkg::IDX_SHORT_END));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state     <= arp_pkg::ST_IDLE;
			act       <= arp_pkg::ACT_NONE;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			byte_idx  <= 5'h00;
			crc       <= 8'h00;
			tx_byte   <= 8'hff;
			new_addr  <= 7'h00;
			match     <= 2'h0;
			sel_fn    <= 1'b0;
			cmd_valid <= 1'b0;
			pec_ok    <= 1'b0;
			ack_pend  <= 1'b0;
		end else if (stop_det) begin
			state     <= arp_pkg::ST_IDLE;
			cmd_valid <= 1'b0;
			ack_pend  <= 1'b0;
		end else if (start_det) begin
			state    <= arp_pkg::ST_ADDR;
			bit_cnt  <= 4'h0;
			ack_pend <= 1'b0;
			if (!cmd_valid) begin
				crc <= 8'h00; // Repeated start keeps the running code
			end
		end else if (scl_rise && bit_cnt == arp_pkg::BIT_ACK) begin
			bit_cnt  <= 4'h0;
			ack_pend <= 1'b0;
			if (state == arp_pkg::ST_RDATA && sda_s) begin
				state <= arp_pkg::ST_SKIP;
			end
		end else if (scl_rise) begin
			bit_cnt <= bit_cnt + 4'h1;
			shreg   <= rx_byte;
			if (byte_end) begin
				unique case (state)
					arp_pkg::ST_ADDR: begin
						if (rx_byte[7:1] == arp_pkg::ARP_ADDR && !rx_byte[0]) begin
							ack_pend  <= 1'b1;
							crc       <= next_crc;
							cmd_valid <= 1'b0;
							state     <= arp_pkg::ST_CMD;
						end else if (rx_byte[7:1] == arp_pkg::ARP_ADDR && cmd_valid &&
								act == arp_pkg::ACT_GET) begin
							ack_pend <= 1'b1;
							crc      <= next_crc;
							byte_idx <= 5'h00;
							tx_byte  <= arp_pkg::BYTE_COUNT;
							state    <= arp_pkg::ST_RDATA;
						end else begin
							state <= arp_pkg::ST_SKIP;
						end
					end
					arp_pkg::ST_CMD: begin
						crc       <= next_crc;
						act       <= dec_act;
						sel_fn    <= dec_fn;
						byte_idx  <= 5'h00;
						match     <= 2'h3;
						pec_ok    <= 1'b0;
						cmd_valid <= dec_hit;
						ack_pend  <= dec_hit;
						state     <= dec_hit ? arp_pkg::ST_WDATA : arp_pkg::ST_SKIP;
					end
					arp_pkg::ST_WDATA: begin
						crc      <= next_crc;
						byte_idx <= next_idx;
						if (act == arp_pkg::ACT_ASSIGN && byte_idx <= arp_pkg::IDX_PEC) begin
							ack_pend <= 1'b1;
							if (byte_idx == arp_pkg::IDX_PEC) begin
								pec_ok <= (rx_byte == crc) && (match != 2'h0);
							end else if (byte_idx == arp_pkg::IDX_NEW_ADDR) begin
								new_addr <= rx_byte[7:1];
							end else if (byte_idx >= arp_pkg::IDX_UDID_FIRST) begin
								for (int f = 0; f < 2; f++) begin
									match[f] <= match[f] && rx_byte == udid_byte(f[0],
										4'(arp_pkg::IDX_UDID_BASE - byte_idx),
										subsys_vendor, subsys_device);
								end
							end
						end else if (act != arp_pkg::ACT_GET && act != arp_pkg::ACT_ASSIGN &&
								byte_idx == 5'h00) begin
							ack_pend <= 1'b1;
							pec_ok   <= (rx_byte == crc);
						end else begin
							state <= arp_pkg::ST_SKIP;
						end
					end
					arp_pkg::ST_RDATA: begin
						crc      <= next_crc;
						byte_idx <= next_idx;
						tx_byte  <= next_tx;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// SDA driver: acknowledge slots and read data, released otherwise
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sda_out <= 1'b0;
			sda_oe  <= 1'b0;
		end else if (start_det || stop_det) begin
			sda_oe <= 1'b0;
		end else if (scl_fall) begin
			if (bit_cnt == arp_pkg::BIT_ACK) begin
				sda_oe <= ack_pend;
			end else if (state == arp_pkg::ST_RDATA) begin
				sda_oe <= ~tx_byte[~bit_cnt[2:0]];
			end else begin
				sda_oe <= 1'b0;
			end
		end
	end

	generate
		for (genvar g = 0; g < 2; g++) begin : g_func
			assign cur_addr[g] = assigned[g] ? asg_addr[g] : dflt_addr[g];

			// Each function keeps its own flag and address
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					address_resolved_flag[g] <= 1'b0;
					assigned[g]              <= 1'b0;
					asg_addr[g]              <= 7'h00;
				end else if (commit) begin
					unique case (act)
						arp_pkg::ACT_PREP: address_resolved_flag[g] <= 1'b0;
						arp_pkg::ACT_RST_ALL: begin
							address_resolved_flag[g] <= 1'b0;
							assigned[g]              <= 1'b0;
						end
						arp_pkg::ACT_RST_ONE: begin
							if (sel_fn == g[0]) begin
								address_resolved_flag[g] <= 1'b0;
								assigned[g]              <= 1'b0;
							end
						end
						arp_pkg::ACT_ASSIGN: begin
							if (match[g]) begin
								asg_addr[g]              <= new_addr;
								assigned[g]              <= 1'b1;
								address_resolved_flag[g] <= 1'b1;
							end
						end
						default: begin
						end
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tsens_addr     <= 7'h00;
			mem_addr       <= 7'h00;
			tsens_resolved <= 1'b0;
			mem_resolved   <= 1'b0;
		end else begin
			tsens_addr     <= cur_addr[0];
			mem_addr       <= cur_addr[1];
			tsens_resolved <= address_resolved_flag[0];
			mem_resolved   <= address_resolved_flag[1];
		end
	end

	sequence commit_s(arp_pkg::act_type a);
		commit && act == a;
	endsequence

	sequence read_ack_s;
		byte_end && state == arp_pkg::ST_ADDR && rx_byte[0] && cmd_valid &&
			rx_byte[7:1] == arp_pkg::ARP_ADDR && act == arp_pkg::ACT_GET;
	endsequence

	prep_clears_flag_a: assert property (commit_s(arp_pkg::ACT_PREP) |=>
		address_resolved_flag == 2'h0) else $error("prepare left a resolved flag set");
	general_reset_a: assert property (commit_s(arp_pkg::ACT_RST_ALL) |=> ##1
		tsens_addr == dflt_addr[0] && mem_addr == dflt_addr[1])
		else $error("general reset did not restore defaults");
	directed_reset_a: assert property (commit_s(arp_pkg::ACT_RST_ONE) |=>
		!assigned[$past(sel_fn)]) else $error("directed reset kept assigned address");
	assign_at_stop_a: assert property ($rose(address_resolved_flag[0]) ||
		$rose(address_resolved_flag[1]) |-> $past(stop_det))
		else $error("address adopted before stop");
	full_match_a: assert property ($rose(address_resolved_flag[1]) |->
		$past(match[1]) && cur_addr[1] == $past(new_addr)) else $error("assign without match");
	bad_pec_a: assert property (stop_det && !pec_ok |=>
		$stable(address_resolved_flag) && $stable(assigned))
		else $error("bad code byte changed state");
	general_get_a: assert property (byte_end && state == arp_pkg::ST_CMD &&
		rx_byte == arp_pkg::CMD_GET && dec_hit |-> !address_resolved_flag[dec_fn])
		else $error("resolved function answered general request");
	get_refused_a: assert property (byte_end && state == arp_pkg::ST_CMD &&
		rx_byte == arp_pkg::CMD_GET && address_resolved_flag == 2'h3 |=>
		!ack_pend && state == arp_pkg::ST_SKIP)
		else $error("general request acknowledged with both functions resolved");
	count_first_a: assert property (read_ack_s |=> tx_byte == arp_pkg::BYTE_COUNT &&
		state == arp_pkg::ST_RDATA) else $error("read did not start with byte count");
	ack_slot_a: assert property (scl_fall && bit_cnt == arp_pkg::BIT_ACK && ack_pend
		&& !start_det && !stop_det |=> sda_oe) else $error("acknowledge not driven");

endmodule

/* arp_host_model.sv */
// Behavioural bus host that runs address resolution transactions against the agent.
// Assumes the bench resolves the open-drain data line and feeds it back as sda_line.
`timescale 1ns/1ps

module arp_host_model #(
	parameter int HALF = 8
) (
	input  wire logic ref_clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	logic [7:0] wbuf [0:17];
	logic [7:0] rbuf [0:18];
	logic [7:0] crc;
	logic       pec_good;

	// Bus clock stands high and data is released outside frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		crc = 8'h00;
		pec_good = 1'b0;
	end

	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
		return r;
	endfunction

	task automatic wait_half();
		repeat (HALF) @(negedge ref_clk);
	endtask

	// Data only moves a couple of cycles after the clock fell, so it never races it
	task automatic start_cond();
		repeat (2) @(negedge ref_clk);
		sda_drv = 1'b1;
		wait_half();
		scl = 1'b1;
		wait_half();
		sda_drv = 1'b0;
		wait_half();
		scl = 1'b0;
	endtask

	task automatic stop_cond();
		repeat (2) @(negedge ref_clk);
		sda_drv = 1'b0;
		wait_half();
		scl = 1'b1;
		wait_half();
		sda_drv = 1'b1;
		wait_half();
	endtask

	task automatic clk_bit(input logic b, output logic s);
		repeat (2) @(negedge ref_clk);
		sda_drv = b;
		wait_half();
		scl = 1'b1;
		wait_half();
		s = sda_line;
		scl = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'b1, s);
		ack = !s;
		crc = crc_step(crc, b);
	endtask

	task automatic recv_byte(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
		clk_bit(last, s);
		crc = crc_step(crc, b);
	endtask

	// Leaves the bus open after the error code byte; the caller issues the stop
	task automatic arp_write(input logic [7:0] cmd, input int n, input logic bad_pec,
			output logic ok);
		logic a;
		crc = 8'h00;
		start_cond();
		send_byte({arp_pkg::ARP_ADDR, 1'b0}, ok);
		if (ok) send_byte(cmd, ok);
		for (int i = 0; i < n; i++) if (ok) begin
			send_byte(wbuf[i], a);
			ok = a;
		end
		if (ok) begin
			send_byte(crc ^ {7'h00, bad_pec}, a);
			ok = a;
		end
	endtask

	task automatic arp_get(input logic [7:0] cmd, output logic ok);
		crc = 8'h00;
		start_cond();
		send_byte({arp_pkg::ARP_ADDR, 1'b0}, ok);
		if (ok) send_byte(cmd, ok);
		if (ok) begin
			start_cond();
			send_byte({arp_pkg::ARP_ADDR, 1'b1}, ok);
		end
		if (ok) for (int i = 0; i < 19; i++) recv_byte(i == 18, rbuf[i]);
		pec_good = (crc == 8'h00);
		stop_cond();
	endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the address resolution agent, driven by the host model.
// Assumes a pull-up on the data line and select pins tied to 3'b101 throughout.
`timescale 1ns/1ps

module tb_top;
	localparam int CEIL = 90000;
	logic        ref_clk;
	logic        rst;
	logic        scl;
	logic        host_sda;
	logic        sda_line;
	logic        sda_out;
	logic        sda_oe;
	logic [2:0]  sel;
	logic [15:0] sv;
	logic [15:0] sd;
	logic        load;
	logic [6:0]  tsens_addr;
	logic [6:0]  mem_addr;
	logic        tsens_resolved;
	logic        mem_resolved;
	logic        ok;
	int          n_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;

	assign sda_line = sda_oe ? (sda_out & host_sda) : host_sda;

	smbus_arp_slave_agent smbus_arp_slave_agent_inst (
		.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_select_in0(sel[0]),
		.addr_select_in1(sel[1]), .addr_select_in2(sel[2]), .subsys_vendor_in(sv),
		.subsys_device_in(sd), .subsys_load(load), .tsens_addr(tsens_addr),
		.mem_addr(mem_addr), .tsens_resolved(tsens_resolved), .mem_resolved(mem_resolved)
	);

	arp_host_model arp_host_model_inst (
		.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda)
	);

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic close_out();
		if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == CEIL) begin
			n_errors++;
			close_out();
		end
	end

	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [127:0] udid(input logic fn, input logic [15:0] v,
			input logic [15:0] d);
		return {8'h80, arp_pkg::UDID_VERSION, arp_pkg::UDID_VENDOR,
			arp_pkg::UDID_DEVICE | {15'h0000, fn}, 16'h0005, v, d, arp_pkg::UDID_VSPEC};
	endfunction

	task automatic check_state(input logic [6:0] ta, input logic tr, input logic [6:0] ma,
			input logic mr);
		check("tsens_addr", tsens_addr, ta);
		check("tsens_resolved", tsens_resolved, tr);
		check("mem_addr", mem_addr, ma);
		check("mem_resolved", mem_resolved, mr);
	endtask

	task automatic check_get(input logic [7:0] cmd, input logic [127:0] u, input logic [6:0] a);
		logic [127:0] got;
		arp_host_model_inst.arp_get(cmd, ok);
		check("get ack", ok, 1'b1);
		check("count", arp_host_model_inst.rbuf[0], 8'h11);
		for (int i = 0; i < 16; i++) got[127-8*i -: 8] = arp_host_model_inst.rbuf[i+1];
		check("udid", got, u);
		check("addr byte", arp_host_model_inst.rbuf[17], {a, 1'b1});
		check("read pec", arp_host_model_inst.pec_good, 1'b1);
	endtask

	task automatic load_assign(input logic [127:0] u, input logic [6:0] a);
		arp_host_model_inst.wbuf[0] = 8'h11;
		for (int i = 0; i < 16; i++) arp_host_model_inst.wbuf[i+1] = u[127-8*i -: 8];
		arp_host_model_inst.wbuf[17] = {a, 1'b0};
	endtask

	task automatic do_write(input logic [7:0] cmd, input int n, input logic bad);
		arp_host_model_inst.arp_write(cmd, n, bad, ok);
		arp_host_model_inst.stop_cond();
	endtask

	task automatic t_defaults_and_general_get();
		check_state(7'h1d, 1'b0, 7'h55, 1'b0);
		check_get(8'h03, udid(1'b0, 16'h0000, 16'h0000), 7'h1d);
	endtask

	task automatic t_assign_sensor();
		load_assign(udid(1'b0, 16'h0000, 16'h0000), 7'h20);
		arp_host_model_inst.arp_write(8'h04, 18, 1'b0, ok);
		check("assign ack", ok, 1'b1);
		check_state(7'h1d, 1'b0, 7'h55, 1'b0);
		arp_host_model_inst.stop_cond();
		check_state(7'h20, 1'b1, 7'h55, 1'b0);
	endtask

	task automatic t_assign_memory();
		check_get(8'h03, udid(1'b1, 16'h0000, 16'h0000), 7'h55);
		load_assign(udid(1'b1, 16'h0000, 16'h0000) ^ 128'h1, 7'h22);
		do_write(8'h04, 18, 1'b0);
		check_state(7'h20, 1'b1, 7'h55, 1'b0);
		load_assign(udid(1'b1, 16'h0000, 16'h0000), 7'h22);
		do_write(8'h04, 18, 1'b1);
		check_state(7'h20, 1'b1, 7'h55, 1'b0);
		do_write(8'h04, 18, 1'b0);
		check_state(7'h20, 1'b1, 7'h22, 1'b1);
		arp_host_model_inst.arp_get(8'h03, ok);
		check("general get refused", ok, 1'b0);
	endtask

	// Stored subsystem fields must show up in both identifiers
	task automatic t_directed_get();
		@(negedge ref_clk);
		sv = 16'h5a5a;
		sd = 16'hc3c3;
		load = 1'b1;
		@(negedge ref_clk);
		load = 1'b0;
		check_get({7'h20, 1'b1}, udid(1'b0, 16'h5a5a, 16'hc3c3), 7'h20);
		check_get({7'h22, 1'b1}, udid(1'b1, 16'h5a5a, 16'hc3c3), 7'h22);
	endtask

	task automatic t_resets();
		do_write({7'h22, 1'b0}, 0, 1'b0);
		check_state(7'h20, 1'b1, 7'h55, 1'b0);
		do_write(8'h01, 0, 1'b0);
		check("prepare ack", ok, 1'b1);
		check_state(7'h20, 1'b0, 7'h55, 1'b0);
		do_write(8'h05, 0, 1'b0);
		check("unknown command", ok, 1'b0);
		do_write(8'h02, 0, 1'b1);
		check_state(7'h20, 1'b0, 7'h55, 1'b0);
		do_write(8'h02, 0, 1'b0);
		check_state(7'h1d, 1'b0, 7'h55, 1'b0);
	endtask

	initial begin
		rst = 1'b1;
		sel = 3'b101;
		sv = 16'h0000;
		sd = 16'h0000;
		load = 1'b0;
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		repeat (6) @(negedge ref_clk);
		t_defaults_and_general_get();
		t_assign_sensor();
		t_assign_memory();
		t_directed_get();
		t_resets();
		close_out();
	end
endmodule
